// ### ccr_config_bank.sv
// Charger configuration bank behind a two-wire serial slave
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Answer only device address 09h
// - Input-off bit opens only input pass path
// - Input floor: 3.88V plus 80mV per code
// - Input cap 85mA+45mA steps, top 455mA
// - Writing reset bit restores all defaults
// - Charge inhibit bit, powers up inhibited
// - Battery undervoltage: 2.4V plus 0.1V steps
// - Fast charge: 8mA plus 17mA steps
// - Discharge cap 200mA steps; host avoids zero
// - Board overtemp protection on when zero
// - Pre-charge 6mA+7mA steps, also termination
// - Regulation 3.60V plus 15mV steps
// - Pre-charge threshold and recharge hysteresis selects
module ccr_config_bank import ccr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output ccr_cfg_t cfg_o,
  output ccr_dec_t dec_o,
  output logic host_kick,
  output logic host_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  logic scl_s;  // Filtered clock line
  logic sda_s;  // Filtered data line
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  ccr_pin_sync u_scl_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(scl_i),
    .level(scl_s)
  );

  ccr_pin_sync u_sda_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(sda_i),
    .level(sda_s)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Edges and bus conditions; a data change while the clock is high is a start or stop
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and read mux

  ccr_cfg_t cfg_q;  // Stored bank
  ccr_cfg_t cfg_d;
  logic kick_q;     // Watchdog kick pulse
  logic kick_d;
  logic mode_q;     // Host mode flag
  logic mode_d;
  logic wr_en;      // One-cycle write strobe from the link
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ptr_q;  // Register pointer
  logic [7:0] rd_byte;

  // Read mux; unmapped indices read zero
  always_comb begin
    if (ptr_q == REG_ISC) begin
      rd_byte = cfg_q.isc;
    end else if (ptr_q == REG_POC) begin
      rd_byte = cfg_q.poc;
    end else if (ptr_q == REG_CCC) begin
      rd_byte = cfg_q.ccc;
    end else if (ptr_q == REG_PDC) begin
      rd_byte = cfg_q.pdc;
    end else if (ptr_q == REG_CVC) begin
      rd_byte = cfg_q.cvc;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Write handling; reserved bits are simply stored
  always_comb begin
    cfg_d = cfg_q;
    kick_d = 1'b0;
    mode_d = mode_q;
    if (wr_en) begin
      // Any write except a register reset moves the device into host mode
      mode_d = 1'b1;
      if (wr_addr == REG_ISC) begin
        cfg_d.isc = ccr_isc_t'(wr_data);
      end else if (wr_addr == REG_POC) begin
        if (wr_data[POC_RESET_BIT]) begin
          // Full return to defaults, back to default mode
          cfg_d = CFG_DEFAULT;
          mode_d = 1'b0;
        end else begin
          // Action bits never stay set
          cfg_d.poc = ccr_poc_t'(wr_data);
          cfg_d.poc.reg_reset = 1'b0;
          cfg_d.poc.host_kick = 1'b0;
          kick_d = wr_data[POC_KICK_BIT];
        end
      end else if (wr_addr == REG_CCC) begin
        cfg_d.ccc = ccr_ccc_t'(wr_data);
      end else if (wr_addr == REG_PDC) begin
        cfg_d.pdc = ccr_pdc_t'(wr_data);
      end else if (wr_addr == REG_CVC) begin
        cfg_d.cvc = ccr_cvc_t'(wr_data);
      end
    end
  end

  // Bank registers; power-on values include charge inhibited
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_DEFAULT;
      kick_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      kick_q <= kick_d;
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Physical decode, registered

  ccr_dec_t dec_w;
  ccr_dec_t dec_q;

  ccr_field_decode u_decode (
    .cfg(cfg_q),
    .dec(dec_w)
  );

  // Decoded settings held in flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave

  ccr_state_t state_q;
  ccr_state_t state_d;
  ccr_phase_t phase_q;  // Which byte is being received
  ccr_phase_t phase_d;
  logic [7:0] sr_q;     // Shift register
  logic [7:0] sr_d;
  logic [2:0] cnt_q;    // Bit count
  logic [2:0] cnt_d;
  logic full_q;         // Eighth bit taken
  logic full_d;
  logic rw_q;           // Read requested
  logic rw_d;
  logic nack_q;         // Master refused next byte
  logic nack_d;
  logic oe_q;           // Pulling the data line low
  logic oe_d;
  logic [7:0] ptr_d;

  // Next state; start and stop win from any state
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    sr_d = sr_q;
    cnt_d = cnt_q;
    full_d = full_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    ptr_d = ptr_q;
    wr_en = 1'b0;
    wr_addr = ptr_q;
    wr_data = sr_q;
    if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start_cond) begin
      // Start or repeated start: expect an address
      state_d = ST_RX;
      phase_d = PH_ADDR;
      cnt_d = 3'h0;
      full_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            // Sample data while the clock is high
            sr_d = {sr_q[6:0], sda_s};
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == 3'h7);
          end else if (scl_fall && full_q) begin
            full_d = 1'b0;
            state_d = ST_ACK;
            oe_d = 1'b1;
            case (phase_q)
              PH_ADDR: begin
                if (sr_q[7:1] == DEV_ADDR) begin
                  rw_d = sr_q[0];
                end else begin
                  // Not ours: stay off the bus until the next start
                  state_d = ST_IDLE;
                  oe_d = 1'b0;
                end
              end
              PH_PTR: begin
                ptr_d = sr_q;
              end
              default: begin
                // Data byte: write and advance the pointer
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_d = 3'h0;
            if (phase_q == PH_ADDR && rw_q) begin
              // Read: present the first bit at once
              state_d = ST_TX;
              sr_d = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d = ~rd_byte[7];
            end else begin
              state_d = ST_RX;
              phase_d = (phase_q == PH_ADDR) ? PH_PTR : PH_DATA;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 3'h1;
            sr_d = {sr_q[6:0], 1'b0};
            if (cnt_q == 3'h7) begin
              // Release for the master's answer
              state_d = ST_TACK;
              oe_d = 1'b0;
            end else begin
              oe_d = ~sr_q[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end else if (scl_fall) begin
            cnt_d = 3'h0;
            if (nack_q) begin
              state_d = ST_IDLE;
            end else begin
              // Acknowledged: send the next register
              state_d = ST_TX;
              sr_d = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d = ~rd_byte[7];
            end
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Link state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      sr_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_q <= 8'h00;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      ptr_q <= ptr_d;
    end
  end

  // Open-drain: the driven level is always low
  logic sda_o_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  // Outputs, all from flops
  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign cfg_o = cfg_q;
  assign dec_o = dec_q;
  assign host_kick = kick_q;
  assign host_mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic addr_byte;
  assign addr_byte = state_q == ST_RX && phase_q == PH_ADDR && scl_fall && full_q && !start_cond && !stop_cond;

  sequence s_kick_write;
    wr_en && wr_addr == REG_POC && !wr_data[POC_RESET_BIT] && wr_data[POC_KICK_BIT];
  endsequence

  sequence s_kick_pulse;
    host_kick ##1 !host_kick;
  endsequence

  a_addr_reject: assert property (addr_byte && sr_q[7:1] != DEV_ADDR |=> state_q == ST_IDLE && !sda_oe)
    else $error("foreign address was acknowledged");
  a_addr_accept: assert property (addr_byte && sr_q[7:1] == DEV_ADDR |=> state_q == ST_ACK && sda_oe)
    else $error("own address not acknowledged");
  a_input_off: assert property (!$past(rst) |-> dec_q.ldo_off == $past(cfg_q.isc.input_path_off))
    else $error("input off bit not carried to pass device");
  a_vin_floor: assert property (!$past(rst) |->
    dec_q.vin_floor_mv == VIN_BASE_MV + VIN_STEP_MV * 16'($past(cfg_q.isc.input_voltage_floor)))
    else $error("input floor decode wrong");
  a_icap_top: assert property (!$past(rst) && $past(cfg_q.isc.input_current_cap) == IIN_TOP_CODE |->
    dec_q.iin_cap_ma == IIN_TOP_MA)
    else $error("top input current code wrong");
  a_soft_reset: assert property (wr_en && wr_addr == REG_POC && wr_data[POC_RESET_BIT] |=>
    cfg_q == CFG_DEFAULT && !host_mode)
    else $error("register reset did not restore defaults");
  a_keep_zero: assert property (wr_en && wr_addr == REG_POC && !wr_data[POC_RESET_BIT] |=>
    cfg_q.isc == $past(cfg_q.isc) && cfg_q.cvc == $past(cfg_q.cvc))
    else $error("zero reset bit changed other registers");
  a_kick_once: assert property (s_kick_write |=> s_kick_pulse)
    else $error("kick pulse not one cycle");
  a_inhibit: assert property (!$past(rst) |-> dec_q.charge_en == !$past(cfg_q.poc.charge_inhibit))
    else $error("charge inhibit polarity wrong");
  a_uvlo_dec: assert property (!$past(rst) |->
    dec_q.uvlo_mv == UVLO_BASE_MV + UVLO_STEP_MV * 16'($past(cfg_q.poc.battery_undervoltage_threshold)))
    else $error("undervoltage decode wrong");
  a_icc_dec: assert property (!$past(rst) |->
    dec_q.icc_ma == ICC_BASE_MA + ICC_STEP_MA * 16'($past(cfg_q.ccc.fast_charge_current)))
    else $error("fast charge decode wrong");
  a_dsch_dec: assert property (!$past(rst) |->
    dec_q.idsch_ma == DSCH_BASE_MA + DSCH_STEP_MA * 16'($past(cfg_q.pdc.discharge_current_cap)))
    else $error("discharge decode wrong");
  a_otp_sel: assert property (!$past(rst) |->
    dec_q.board_otp_en == !$past(cfg_q.pdc.board_overtemp_select))
    else $error("board overtemp select polarity wrong");
  a_pre_term: assert property (!$past(rst) |-> dec_q.iterm_ma == dec_q.precharge_current_ma &&
    dec_q.precharge_current_ma == PRECHARGE_CURRENT_BASE_MA + PRECHARGE_CURRENT_STEP_MA * 16'($past(cfg_q.pdc.precharge_current)))
    else $error("precharge or termination decode wrong");
  a_vreg_dec: assert property (!$past(rst) |->
    dec_q.vreg_mv == VREG_BASE_MV + VREG_STEP_MV * 16'($past(cfg_q.cvc.battery_regulation_voltage)))
    else $error("regulation voltage decode wrong");
  a_thr_hyst: assert property (!$past(rst) |->
    dec_q.vpre_mv == ($past(cfg_q.cvc.precharge_threshold) ? VPRE_HI_MV : VPRE_LO_MV) &&
    dec_q.recharge_hysteresis_mv == ($past(cfg_q.cvc.recharge_hysteresis) ? RECHARGE_HYSTERESIS_HI_MV : RECHARGE_HYSTERESIS_LO_MV))
    else $error("threshold or hysteresis select wrong");
  a_rsv_echo: assert property (wr_en && wr_addr == REG_CCC |=> cfg_q.ccc == $past(wr_data))
    else $error("reserved bits not stored");

endmodule
`default_nettype wire

// ### ccr_pkg.sv
// Shared constants, field layouts and types for the charger configuration bank
package ccr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial link
  localparam logic [6:0] DEV_ADDR = 7'h09;  // Fixed 7-bit device address

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [7:0] REG_ISC = 8'h00;  // input_source_control
  localparam logic [7:0] REG_POC = 8'h01;  // power_on_configuration
  localparam logic [7:0] REG_CCC = 8'h02;  // charge_current_control
  localparam logic [7:0] REG_PDC = 8'h03;  // precharge_discharge_current
  localparam logic [7:0] REG_CVC = 8'h04;  // charge_voltage_control

  // Power-on values
  localparam logic [7:0] RST_ISC = 8'h07;
  localparam logic [7:0] RST_POC = 8'h0d;
  localparam logic [7:0] RST_CCC = 8'h07;
  localparam logic [7:0] RST_PDC = 8'h1c;
  localparam logic [7:0] RST_CVC = 8'h86;

  // Bit positions of the action bits in power_on_configuration
  localparam int unsigned POC_RESET_BIT = 7;
  localparam int unsigned POC_KICK_BIT = 6;

  // Input current code that leaves the linear ladder
  localparam logic [2:0] IIN_TOP_CODE = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Decode scales, mV or mA
  localparam logic [15:0] VIN_BASE_MV = 16'h0f28;   // 3880
  localparam logic [15:0] VIN_STEP_MV = 16'h0050;   // 80
  localparam logic [15:0] IIN_BASE_MA = 16'h0055;   // 85
  localparam logic [15:0] IIN_STEP_MA = 16'h002d;   // 45
  localparam logic [15:0] IIN_TOP_MA = 16'h01c7;    // 455
  localparam logic [15:0] UVLO_BASE_MV = 16'h0960;  // 2400
  localparam logic [15:0] UVLO_STEP_MV = 16'h0064;  // 100
  localparam logic [15:0] ICC_BASE_MA = 16'h0008;   // 8
  localparam logic [15:0] ICC_STEP_MA = 16'h0011;   // 17
  localparam logic [15:0] DSCH_BASE_MA = 16'h00c8;  // 200
  localparam logic [15:0] DSCH_STEP_MA = 16'h00c8;  // 200
  localparam logic [15:0] PRECHARGE_CURRENT_BASE_MA = 16'h0006;  // 6
  localparam logic [15:0] PRECHARGE_CURRENT_STEP_MA = 16'h0007;  // 7
  localparam logic [15:0] VREG_BASE_MV = 16'h0e10;  // 3600
  localparam logic [15:0] VREG_STEP_MV = 16'h000f;  // 15
  localparam logic [15:0] VPRE_LO_MV = 16'h0af0;    // 2800
  localparam logic [15:0] VPRE_HI_MV = 16'h0bb8;    // 3000
  localparam logic [15:0] RECHARGE_HYSTERESIS_LO_MV = 16'h0096;   // 150
  localparam logic [15:0] RECHARGE_HYSTERESIS_HI_MV = 16'h012c;   // 300

  ////////////////////////////////////////////////////////////////////////////
  // Register layouts
  typedef struct packed {
    logic input_path_off;
    logic [3:0] input_voltage_floor;
    logic [2:0] input_current_cap;
  } ccr_isc_t;

  typedef struct packed {
    logic reg_reset;
    logic host_kick;
    logic [1:0] rsv;
    logic charge_inhibit;
    logic [2:0] battery_undervoltage_threshold;
  } ccr_poc_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic [4:0] fast_charge_current;
  } ccr_ccc_t;

  typedef struct packed {
    logic rsv;
    logic [3:0] discharge_current_cap;
    logic board_overtemp_select;
    logic [1:0] precharge_current;
  } ccr_pdc_t;

  typedef struct packed {
    logic [5:0] battery_regulation_voltage;
    logic precharge_threshold;
    logic recharge_hysteresis;
  } ccr_cvc_t;

  // Whole bank, highest index first
  typedef struct packed {
    ccr_cvc_t cvc;
    ccr_pdc_t pdc;
    ccr_ccc_t ccc;
    ccr_poc_t poc;
    ccr_isc_t isc;
  } ccr_cfg_t;

  localparam ccr_cfg_t CFG_DEFAULT = {RST_CVC, RST_PDC, RST_CCC, RST_POC, RST_ISC};

  // Settings turned into physical units for the analog side
  typedef struct packed {
    logic [15:0] vin_floor_mv;
    logic [15:0] iin_cap_ma;
    logic [15:0] uvlo_mv;
    logic [15:0] icc_ma;
    logic [15:0] idsch_ma;
    logic [15:0] precharge_current_ma;
    logic [15:0] iterm_ma;
    logic [15:0] vreg_mv;
    logic [15:0] vpre_mv;
    logic [15:0] recharge_hysteresis_mv;
    logic ldo_off;
    logic charge_en;
    logic board_otp_en;
  } ccr_dec_t;

  // Serial slave states and byte phases
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK} ccr_state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} ccr_phase_t;

endpackage

// ### ccr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module ccr_pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  logic [2:0] stage_q;  // Stage 0 meets the pin
  logic [2:0] stage_d;
  logic level_q;        // Accepted level
  logic level_d;

  // Shift the pin in; accept a change once stages 1 and 2 agree
  always_comb begin
    stage_d = {stage_q[1:0], pin};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  // Idle bus level is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_q <= 3'h7;
      level_q <= 1'b1;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule
`default_nettype wire

// ### ccr_field_decode.sv
// Turns stored register codes into physical settings
`timescale 1ns/10ps
`default_nettype none

module ccr_field_decode import ccr_pkg::*; (
  input wire ccr_cfg_t cfg,
  output ccr_dec_t dec
);

  // Each ladder field is a base plus a binary weighted step; the two selects pick one of two fixed values
  always_comb begin
    dec = '0;
    dec.vin_floor_mv = VIN_BASE_MV + VIN_STEP_MV * 16'(cfg.isc.input_voltage_floor);
    // Top code jumps above the ladder
    if (cfg.isc.input_current_cap == IIN_TOP_CODE) begin
      dec.iin_cap_ma = IIN_TOP_MA;
    end else begin
      dec.iin_cap_ma = IIN_BASE_MA + IIN_STEP_MA * 16'(cfg.isc.input_current_cap);
    end
    dec.uvlo_mv = UVLO_BASE_MV + UVLO_STEP_MV * 16'(cfg.poc.battery_undervoltage_threshold);
    dec.icc_ma = ICC_BASE_MA + ICC_STEP_MA * 16'(cfg.ccc.fast_charge_current);
    dec.idsch_ma = DSCH_BASE_MA + DSCH_STEP_MA * 16'(cfg.pdc.discharge_current_cap);
    // Same setting drives pre-charge and termination
    dec.precharge_current_ma = PRECHARGE_CURRENT_BASE_MA + PRECHARGE_CURRENT_STEP_MA * 16'(cfg.pdc.precharge_current);
    dec.iterm_ma = dec.precharge_current_ma;
    dec.vreg_mv = VREG_BASE_MV + VREG_STEP_MV * 16'(cfg.cvc.battery_regulation_voltage);
    dec.vpre_mv = cfg.cvc.precharge_threshold ? VPRE_HI_MV : VPRE_LO_MV;
    dec.recharge_hysteresis_mv = cfg.cvc.recharge_hysteresis ? RECHARGE_HYSTERESIS_HI_MV : RECHARGE_HYSTERESIS_LO_MV;
    // Only the input pass device; battery path untouched
    dec.ldo_off = cfg.isc.input_path_off;
    dec.charge_en = ~cfg.poc.charge_inhibit;
    dec.board_otp_en = ~cfg.pdc.board_overtemp_select;
  end

endmodule
`default_nettype wire

// ### ccr_host.sv
// Two-wire host model for the charger bank
`timescale 1ns/10ps
`default_nettype none

module ccr_host import ccr_pkg::*; (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Bus idles with both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Third of a bit time
  task automatic qb();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // Send one bit, data moved only while the clock is low
  task automatic put(input logic b);
    qb();
    sda_low = ~b;
    qb();
    scl = 1'b1;
    qb();
    scl = 1'b0;
  endtask
  // Take one bit late in the high phase
  task automatic get(output logic b);
    qb();
    sda_low = 1'b0;
    qb();
    scl = 1'b1;
    qb();
    b = sda;
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    qb();
    sda_low = 1'b0;
    qb();
    scl = 1'b1;
    qb();
    sda_low = 1'b1;
    qb();
    scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    qb();
    sda_low = 1'b1;
    qb();
    scl = 1'b1;
    qb();
    sda_low = 1'b0;
    qb();
  endtask
  // Send a byte, most significant bit first, and take the ack
  task automatic tx(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put(d[i]);
    end
    get(a);
    ack = ~a;
  endtask
  // Receive a byte, then ack (0) or refuse (1)
  task automatic rx(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get(d[i]);
    end
    put(last);
  endtask
  // Single-byte write; ok only if all three bytes were acked
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
    logic k1;
    logic k2;
    logic k3;
    start();
    tx({a, 1'b0}, k1);
    tx(idx, k2);
    tx(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // Pointer write, repeated start, one byte read with refusal
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic k;
    start();
    tx({DEV_ADDR, 1'b0}, k);
    tx(idx, k);
    start();
    tx({DEV_ADDR, 1'b1}, k);
    rx(1'b1, d);
    stop();
  endtask
  // Pointer write, repeated start, two bytes read: ack the first, refuse the second
  task automatic rd2(input logic [7:0] idx, output logic [7:0] d0, output logic [7:0] d1);
    logic k;
    start();
    tx({DEV_ADDR, 1'b0}, k);
    tx(idx, k);
    start();
    tx({DEV_ADDR, 1'b1}, k);
    rx(1'b0, d0);
    rx(1'b1, d1);
    stop();
  endtask
endmodule

`default_nettype wire

// ### tb.sv
// Self-checking bench for the charger configuration bank
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ccr_pkg::*;
  logic sys_clk;
  logic rst;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic host_kick;
  logic host_mode;
  logic sda_w;
  ccr_cfg_t cfg_o;
  ccr_dec_t dec_o;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int kicks = 0;
  // Rows: index, byte written, byte read back
  logic [23:0] rows [6] = '{
    24'h00ffff,  // Input path off, top floor and cap
    24'h013737,  // Charging on, top threshold
    24'h02e5e5,  // Reserved bits kept
    24'h03fafa,  // Top discharge code
    24'h04fdfd,  // Top regulation code
    24'h095500   // Unmapped index reads zero
  };
  // Open-drain data line with pull-up
  assign sda_w = ~((sda_oe & ~sda_o) | sda_low);
  ccr_config_bank uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .cfg_o(cfg_o),
    .dec_o(dec_o),
    .host_kick(host_kick),
    .host_mode(host_mode)
  );
  ccr_host h (
    .sys_clk(sys_clk),
    .sda(sda_w),
    .scl(scl),
    .sda_low(sda_low)
  );
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard and kick pulse counter
  always @(posedge sys_clk) begin
    cyc++;
    if (host_kick === 1'b1) begin
      kicks++;
    end
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] v2;
    logic ok;
    int n;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check(cfg_o, CFG_DEFAULT);
    check(host_mode, 1'b0);
    h.rd(REG_CVC, v);
    check(v, RST_CVC);
    h.wr(7'h0a, REG_ISC, 8'h00, ok);
    check(ok, 1'b0);
    check(cfg_o, CFG_DEFAULT);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      h.wr(DEV_ADDR, rows[i][23:16], rows[i][15:8], ok);
      check(ok, 1'b1);
      h.rd(rows[i][23:16], v);
      check(v, rows[i][7:0]);
    end
    check(host_mode, 1'b1);
    check(dec_o.vin_floor_mv, 16'h13d8);
    check(dec_o.ldo_off, 1'b1);
    check(dec_o.charge_en, 1'b1);
    check(dec_o.uvlo_mv, 16'h0c1c);
    check(dec_o.icc_ma, 16'h005d);
    check(dec_o.idsch_ma, 16'h0c80);
    check(dec_o.board_otp_en, 1'b1);
    check(dec_o.precharge_current_ma, 16'h0014);
    check(dec_o.iterm_ma, 16'h0014);
    check(dec_o.vreg_mv, 16'h11c1);
    check(dec_o.vpre_mv, 16'h0af0);
    check(dec_o.recharge_hysteresis_mv, 16'h012c);
    $display("test rows done");
    for (int k = 0; k < 8; k++) begin
      h.wr(DEV_ADDR, REG_ISC, 8'(k), ok);
      check(dec_o.iin_cap_ma, (k == 7) ? 16'h01c7 : 16'(85 + 45 * k));
    end
    check(dec_o.ldo_off, 1'b0);
    $display("test input cap done");
    n = kicks;
    h.wr(DEV_ADDR, REG_POC, 8'h40, ok);
    check(kicks - n, 1);
    h.rd(REG_POC, v);
    check(v, 8'h00);
    h.wr(DEV_ADDR, REG_POC, 8'h80, ok);
    check(cfg_o, CFG_DEFAULT);
    check(host_mode, 1'b0);
    check(kicks - n, 1);
    check(dec_o.charge_en, 1'b0);
    check(dec_o.vreg_mv, 16'h0fff);
    $display("test kick and reset done");
    h.rd2(REG_CCC, v, v2);
    check(v, RST_CCC);
    check(v2, RST_PDC);
    $display("test burst read done");
    h.wr(DEV_ADDR, REG_ISC, 8'h80, ok);
    check(cfg_o.isc, 8'h80);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check(cfg_o, CFG_DEFAULT);
    check(host_mode, 1'b0);
    h.rd(REG_ISC, v);
    check(v, RST_ISC);
    $display("test second reset done");
    complete_run();
  end
endmodule

`default_nettype wire
